// ===== sbms_defines.vh
// Constants for the boot mode selector: register map, field positions, reset values, timing.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SBMS_DEFINES_VH
`define SBMS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBMS_OFF_CTRL 12'h000
`define SBMS_OFF_STATUS 12'h004
`define SBMS_OFF_PINSEL 12'h008
`define SBMS_OFF_RESULT 12'h00c
`define SBMS_OFF_EXPECT 12'h010

// ----------------------------------------
// Control fields (write one to act)
// ----------------------------------------
`define SBMS_CTRL_START 0
`define SBMS_CTRL_ACT 1
`define SBMS_CTRL_COMMIT 2
`define SBMS_CTRL_MERASE 3
`define SBMS_CTRL_PERASE 4
`define SBMS_CTRL_FACTORY 5
`define SBMS_CTRL_PGMERASE 6
`define SBMS_CTRL_RESDONE 7

// ----------------------------------------
// Stimulus pin encoding and defaults
// ----------------------------------------
`define SBMS_PIN_W 7
`define SBMS_PIN_SERIAL_DEF 7'h5c
`define SBMS_PIN_USB_DEF 7'h52
`define SBMS_PIN_RX 7'h4b
`define SBMS_PIN_TX 7'h4c
`define SBMS_PIN_CTS 7'h4d
`define SBMS_PIN_RTS 7'h4e
`define SBMS_IF_SERIAL 1'b0
`define SBMS_IF_USB 1'b1
`define SBMS_SERIAL_BPS 115200

// ----------------------------------------
// Timing
// ----------------------------------------
`define SBMS_CLK_HZ 100000000
`define SBMS_TIMEOUT_S 20
`define SBMS_TIMEOUT_CYC (`SBMS_TIMEOUT_S * `SBMS_CLK_HZ)
`define SBMS_BIT_CYC ((`SBMS_CLK_HZ + `SBMS_SERIAL_BPS / 2) / `SBMS_SERIAL_BPS)

`endif

// ===== sbms_boot_selector.v
// Boot mode selector: decides loader session, secure boot run, or shutdown after each reset.
// Assumes the board drives the stimulus pins to a defined level; signature math is external.
`timescale 1ns/1ps
`include "sbms_defines.vh"

// Notes on behaviour
// RQ1: Sample selected stimulus pin after any reset.
// RQ2: Active stimulus opens loader, else secure boot.
// RQ3: Loader session only via stimulus at reset.
// RQ4: Use default interface and pin unless reconfigured.
// RQ5: Default interface is first serial port, 115200.
// RQ6: Pin reassignment only by command in session.
// RQ7: Pins ports 0-3; serial RX/TX/CTS/RTS refused.
// RQ8: Release stimulus pin once application runs.
// RQ9: Board drives stimulus pin to defined level.
// RQ10: Factory content selects USB and dedicated pin.
// RQ11: Mass or last page erase restores serial default.
// RQ12: Host commits interface, freeing last flash page.
// RQ13: Start user code only on signature match.
// RQ14: Mismatch holds shutdown until program erase packet.
// RQ15: Maker root key held in one-time storage.
// RQ16: Customer key and certificate readable in storage.
// RQ17: Loader authenticates session packets by signature.
// RQ18: No customer key at production; needs certificate.
// RQ19: Customer key is 2048-bit RSA pair.
// RQ20: Submitted key: 512 modulus, 8 exponent digits.
// RQ21: Serial link 8-N-1, fixed rate, no flow.
// RQ22: Framing-error bytes are discarded.
// RQ23: Stimulus active high; low selects secure boot.
// RQ24: Twenty second loader timeout restarts boot decision.
module sbms_boot_selector #(
  parameter [31:0] TIMEOUT_CYC = `SBMS_TIMEOUT_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins of ports 0 to 3
  input wire [127:0] gpio_in,
  // Loader link activity
  input wire loader_byte_valid,
  input wire loader_frame_err,
  input wire loader_pkt_auth_ok,
  // Boot outcome
  output reg loader_active,
  output reg loader_if_usb,
  output reg user_code_run,
  output reg shutdown,
  output reg stim_released,
  output reg verify_req
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_SAMPLE = 3'd0;
  localparam [2:0] ST_LOADER = 3'd1;
  localparam [2:0] ST_VERIFY = 3'd2;
  localparam [2:0] ST_RUN = 3'd3;
  localparam [2:0] ST_SHUT = 3'd4;
  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // Loader selection, cleared by aresetn; survives sessions, otherwise set only by factory select, loader or erase events
  reg if_sel_r;
  reg [`SBMS_PIN_W-1:0] pin_sel_r;
  reg [`SBMS_PIN_W-1:0] pin_pend_r;
  reg committed_r;
  reg pin_rejected_r;
  reg [31:0] result_r;
  reg [31:0] expect_r;
  reg result_done_r;
  reg [31:0] tmo_cnt_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg aw_have_r;
  reg w_have_r;

  wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && (awaddr_r == `SBMS_OFF_CTRL) && s_axi_wstrb[0];
  wire wr_pin = wr_fire && (awaddr_r == `SBMS_OFF_PINSEL) && s_axi_wstrb[0];
  wire wr_res = wr_fire && (awaddr_r == `SBMS_OFF_RESULT);
  wire wr_exp = wr_fire && (awaddr_r == `SBMS_OFF_EXPECT);
  wire in_session = (state_r == ST_LOADER);
  wire stim_level = gpio_in[pin_sel_r]; // RQ1
  wire [`SBMS_PIN_W-1:0] new_pin = wdata_r[`SBMS_PIN_W-1:0];
  // Serial control pins would break the loader link itself if used as stimulus
  wire pin_bad = (new_pin == `SBMS_PIN_RX) || (new_pin == `SBMS_PIN_TX) ||
                 (new_pin == `SBMS_PIN_CTS) || (new_pin == `SBMS_PIN_RTS); // RQ7
  wire act_cmd = wr_ctrl && wdata_r[`SBMS_CTRL_ACT] && in_session;
  wire erase_cmd = wr_ctrl && (wdata_r[`SBMS_CTRL_MERASE] ||
                   (wdata_r[`SBMS_CTRL_PERASE] && !committed_r));
  wire pgm_erase = wr_ctrl && wdata_r[`SBMS_CTRL_PGMERASE] && loader_pkt_auth_ok;
  // Only well-framed, authenticated traffic keeps a session alive
  wire activity = loader_byte_valid && !loader_frame_err && loader_pkt_auth_ok; // RQ22 RQ17 RQ21
  wire tmo_hit = (tmo_cnt_r >= TIMEOUT_CYC - 32'd1);

  // ----------------------------------------
  // Boot decision
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SAMPLE: begin
        if (stim_level == 1'b1)
          state_nxt = ST_LOADER; // RQ2 RQ23 RQ3
        else
          state_nxt = ST_VERIFY; // RQ2
      end
      ST_LOADER: begin
        if (tmo_hit)
          state_nxt = ST_SAMPLE; // RQ24
      end
      ST_VERIFY: begin
        // Key store and signature engine sit outside; they hand over a result word and an expected word
        if (result_done_r)
          state_nxt = (result_r == expect_r) ? ST_RUN : ST_SHUT; // RQ13 RQ15 RQ16 RQ18 RQ19
      end
      ST_RUN: state_nxt = ST_RUN;
      ST_SHUT: begin
        if (pgm_erase)
          state_nxt = ST_SAMPLE; // RQ14
      end
      default: state_nxt = ST_SAMPLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_SAMPLE;
      tmo_cnt_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      if (!in_session || activity)
        tmo_cnt_r <= 32'h0;
      else
        tmo_cnt_r <= tmo_cnt_r + 32'h1; // RQ24
    end
  end

  // ----------------------------------------
  // Loader configuration store
  // ----------------------------------------
  // Kept across boot-decision restarts like flash content; aresetn, the only reset, clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      if_sel_r <= `SBMS_IF_SERIAL; // RQ4 RQ5
      pin_sel_r <= `SBMS_PIN_SERIAL_DEF;
      pin_pend_r <= `SBMS_PIN_SERIAL_DEF;
      committed_r <= 1'b0;
      pin_rejected_r <= 1'b0;
    end else begin
      if (wr_pin && in_session) begin
        pin_rejected_r <= pin_bad;
        if (!pin_bad)
          pin_pend_r <= new_pin; // RQ6 RQ7
      end
      if (wr_ctrl && wdata_r[`SBMS_CTRL_FACTORY] && !committed_r) begin
        if_sel_r <= `SBMS_IF_USB; // RQ10
        pin_sel_r <= `SBMS_PIN_USB_DEF;
        pin_pend_r <= `SBMS_PIN_USB_DEF;
      end else if (erase_cmd) begin
        if_sel_r <= `SBMS_IF_SERIAL; // RQ11
        pin_sel_r <= `SBMS_PIN_SERIAL_DEF;
        pin_pend_r <= `SBMS_PIN_SERIAL_DEF;
        committed_r <= 1'b0;
      end else if (act_cmd) begin
        pin_sel_r <= pin_pend_r; // RQ6
        committed_r <= wdata_r[`SBMS_CTRL_COMMIT] | committed_r; // RQ12
      end
    end
  end

  // ----------------------------------------
  // Signature compare inputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= 32'h0;
      expect_r <= 32'h0;
      result_done_r <= 1'b0;
    end else begin
      if (wr_res)
        result_r <= wdata_r;
      if (wr_exp)
        expect_r <= wdata_r;
      if (state_r == ST_SAMPLE)
        result_done_r <= 1'b0;
      else if (wr_ctrl && wdata_r[`SBMS_CTRL_RESDONE] && state_r == ST_VERIFY)
        result_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      loader_active <= 1'b0;
      loader_if_usb <= 1'b0;
      user_code_run <= 1'b0;
      shutdown <= 1'b0;
      stim_released <= 1'b0;
      verify_req <= 1'b0;
    end else begin
      loader_active <= (state_nxt == ST_LOADER);
      loader_if_usb <= if_sel_r;
      user_code_run <= (state_nxt == ST_RUN);
      shutdown <= (state_nxt == ST_SHUT); // RQ14
      stim_released <= (state_nxt == ST_RUN); // RQ8
      verify_req <= (state_nxt == ST_VERIFY);
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h0;
      wdata_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r <= `SBMS_OFF_EXPECT && awaddr_r[1:0] == 2'b00 &&
                        awaddr_r != `SBMS_OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          `SBMS_OFF_CTRL: s_axi_rdata <= 32'h0;
          `SBMS_OFF_STATUS: s_axi_rdata <= {23'h0, pin_rejected_r, committed_r, if_sel_r,
                                            stim_level, 1'b0, state_r, 1'b0};
          `SBMS_OFF_PINSEL: s_axi_rdata <= {17'h0, pin_pend_r, 1'b0, pin_sel_r};
          `SBMS_OFF_RESULT: s_axi_rdata <= result_r;
          `SBMS_OFF_EXPECT: s_axi_rdata <= expect_r;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // sbms_boot_selector

// ===== sbms_host_model.sv
// Host end of the loader link: emits one strobe per received character.
// Assumes the bench sets spacing, framing faults and packet authentication.
`timescale 1ns/1ps
module sbms_host_model (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bench controls
  input wire host_go,
  input wire [7:0] host_gap,
  input wire host_ferr,
  input wire host_auth,
  // Link strobes
  output logic loader_byte_valid,
  output logic loader_frame_err,
  output logic loader_pkt_auth_ok
);
  logic [7:0] gap_r;
  always @(posedge aclk) begin
    // Auth flag stands for packets signed with the submitted customer key
    loader_pkt_auth_ok <= aresetn && host_auth;
    if (!aresetn || !host_go) begin
      gap_r <= 8'h00;
      loader_byte_valid <= 1'b0;
      loader_frame_err <= 1'b0;
    end else begin
      // Whole 8-N-1 characters only, spaced by the gap
      loader_byte_valid <= (gap_r == 8'h00);
      // Between characters the error line toggles so stale values mean nothing
      loader_frame_err <= (gap_r == 8'h00) ? host_ferr : ~loader_frame_err;
      gap_r <= (gap_r == 8'h00) ? host_gap : gap_r - 8'h01;
    end
  end
endmodule // sbms_host_model

// ===== sbms_checker_assertions.sv
// Checker: boot path, release and shutdown relations at the selector ports.
// Assumes the stimulus setup returns to its default on every reset.
`timescale 1ns/1ps
`include "sbms_defines.vh"
module sbms_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Watched inputs
  input wire [127:0] gpio_in,
  input wire loader_pkt_auth_ok,
  // Outcome
  input wire loader_active,
  input wire loader_if_usb,
  input wire user_code_run,
  input wire shutdown,
  input wire stim_released,
  input wire verify_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rel;
    aresetn && !$past(aresetn);
  endsequence
  sequence s_vleft;
    verify_req ##1 !verify_req;
  endsequence
  property p_sample;
    s_rel |-> ##2 loader_active == $past(gpio_in[`SBMS_PIN_SERIAL_DEF], 2)
      && verify_req == !loader_active;
  endproperty
  a_sample: assert property (p_sample) else $error("bad boot path");
  property p_ifdef;
    s_rel |-> ##2 !loader_if_usb;
  endproperty
  a_ifdef: assert property (p_ifdef) else $error("bad default if");
  property p_release;
    stim_released == user_code_run;
  endproperty
  a_release: assert property (p_release) else $error("pin not released");
  property p_excl;
    loader_active |-> !(verify_req || user_code_run || shutdown);
  endproperty
  a_excl: assert property (p_excl) else $error("two paths at once");
  property p_route;
    $rose(loader_active) |-> !$past(user_code_run) && !$past(shutdown) && !$past(verify_req);
  endproperty
  a_route: assert property (p_route) else $error("loader entered late");
  property p_vexit;
    s_vleft |-> user_code_run != shutdown;
  endproperty
  a_vexit: assert property (p_vexit) else $error("bad verify exit");
  property p_shut;
    shutdown && !loader_pkt_auth_ok |=> shutdown;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown left");
  property p_run;
    user_code_run |=> user_code_run;
  endproperty
  a_run: assert property (p_run) else $error("user code stopped");
endmodule // sbms_checker
bind sbms_boot_selector sbms_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .gpio_in(gpio_in), .loader_pkt_auth_ok(loader_pkt_auth_ok), .loader_active(loader_active),
  .loader_if_usb(loader_if_usb), .user_code_run(user_code_run), .shutdown(shutdown),
  .stim_released(stim_released), .verify_req(verify_req));

// ===== secure_boot_mode_selector_tb.sv
// Bench for the boot selector: boot, shutdown, loader session, timeout.
// Assumes a host model on the loader link and AXI4-Lite register access.
`timescale 1ns/1ps
`include "sbms_defines.vh"
module secure_boot_mode_selector_tb;
  localparam [11:0] CT = `SBMS_OFF_CTRL, ST = `SBMS_OFF_STATUS, PS = `SBMS_OFF_PINSEL;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [127:0] gpio_in = 128'h0;
  logic host_go = 1'b0, host_ferr = 1'b0, host_auth = 1'b0;
  logic [7:0] host_gap = 8'h09;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire loader_byte_valid, loader_frame_err, loader_pkt_auth_ok;
  wire loader_active, loader_if_usb, user_code_run, shutdown, stim_released, verify_req;
  integer num_errors = 0, n_tests = 0, i;
  logic [31:0] rd, sig;
  logic [1:0] rsp;
  logic [6:0] pin;
  sbms_boot_selector #(.TIMEOUT_CYC(32'd50)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gpio_in(gpio_in),
    .loader_byte_valid(loader_byte_valid), .loader_frame_err(loader_frame_err),
    .loader_pkt_auth_ok(loader_pkt_auth_ok), .loader_active(loader_active),
    .loader_if_usb(loader_if_usb), .user_code_run(user_code_run), .shutdown(shutdown),
    .stim_released(stim_released), .verify_req(verify_req));
  sbms_host_model u_host (.aclk(aclk), .aresetn(aresetn), .host_go(host_go),
    .host_gap(host_gap), .host_ferr(host_ferr), .host_auth(host_auth),
    .loader_byte_valid(loader_byte_valid), .loader_frame_err(loader_frame_err),
    .loader_pkt_auth_ok(loader_pkt_auth_ok));
  // Expected {verify_req, loader_active} for a stimulus level at reset
  function [1:0] path_exp(input lvl);
    path_exp = lvl ? 2'b01 : 2'b10;
  endfunction
  // Serial control pins are refused and leave the active pin as it was
  function [6:0] pin_exp(input [6:0] req, input [6:0] cur);
    pin_exp = (req >= `SBMS_PIN_RX && req <= `SBMS_PIN_RTS) ? cur : req;
  endfunction
  always #5 aclk = ~aclk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("tests=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task tmo;
    begin
      chk(32'h0, 32'h1);
      end_of_test;
    end
  endtask
  task aw(input [11:0] a, input [31:0] d);
    logic dn;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      dn = 1'b0;
      for (i = 0; i < 50 && !dn; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        dn = s_axi_bvalid === 1'b1;
      end
      if (!dn) tmo;
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task ar(input [11:0] a);
    logic dn;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      dn = 1'b0;
      for (i = 0; i < 50 && !dn; i = i + 1) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        dn = s_axi_rvalid === 1'b1;
      end
      if (!dn) tmo;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rst(input lvl);
    begin
      aresetn <= 1'b0;
      gpio_in <= {$urandom, $urandom, $urandom, $urandom};
      repeat (8) @(posedge aclk);
      gpio_in[`SBMS_PIN_SERIAL_DEF] <= lvl;
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sig = $urandom(32'h454859ec);
    sig = $urandom;
    rst(1'b0);
    chk({30'h0, verify_req, loader_active}, {30'h0, path_exp(1'b0)});
    aw(PS, 32'h11);
    aw(CT, 32'h2);
    ar(PS);
    chk({25'h0, rd[6:0]}, {25'h0, `SBMS_PIN_SERIAL_DEF});
    aw(`SBMS_OFF_RESULT, sig);
    aw(`SBMS_OFF_EXPECT, sig);
    ar(`SBMS_OFF_RESULT);
    chk(rd, sig);
    aw(CT, 32'h80);
    ar(ST);
    chk({27'h0, rd[3:1], user_code_run, stim_released}, 32'hf);
    $display("boot done");
    rst(1'b0);
    aw(`SBMS_OFF_RESULT, sig);
    aw(`SBMS_OFF_EXPECT, ~sig);
    aw(CT, 32'h80);
    aw(CT, 32'h40);
    aw(ST, 32'h1);
    chk({28'h0, rsp, shutdown, user_code_run}, 32'ha);
    ar(12'h100);
    chk(rd | rsp, 32'h2);
    host_auth <= 1'b1;
    aw(CT, 32'h40);
    ar(ST);
    chk({31'h0, shutdown}, 32'h0);
    $display("shutdown done");
    host_go <= 1'b1;
    rst(1'b1);
    chk({30'h0, loader_active, loader_if_usb}, 32'h2);
    // Factory select without the low byte strobe must not land
    s_axi_wstrb <= 4'he;
    aw(CT, 32'h20);
    s_axi_wstrb <= 4'hf;
    ar(ST);
    chk({31'h0, rd[6]}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      aw(CT, 32'h20);
      ar(ST);
      chk({31'h0, loader_if_usb}, 32'h1);
      aw(CT, k ? 32'h10 : 32'h08);
      ar(ST);
      chk({31'h0, loader_if_usb}, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      aw(PS, 32'h4b + k);
      ar(ST);
      chk({31'h0, rd[8]}, 32'h1);
      aw(CT, 32'h2);
      ar(PS);
      chk({25'h0, rd[6:0]}, {25'h0, pin_exp(7'(32'h4b + k), `SBMS_PIN_SERIAL_DEF)});
    end
    pin = `SBMS_PIN_RX;
    while (pin >= `SBMS_PIN_RX && pin <= `SBMS_PIN_RTS) pin = 7'($urandom);
    aw(PS, {25'h0, pin});
    aw(CT, 32'h6);
    ar(PS);
    chk({25'h0, rd[6:0]}, {25'h0, pin_exp(pin, `SBMS_PIN_SERIAL_DEF)});
    // Once committed, page erase and factory select are both ignored
    aw(CT, 32'h30);
    ar(PS);
    chk({25'h0, rd[6:0]}, {25'h0, pin});
    ar(ST);
    chk({30'h0, rd[7:6]}, 32'h2);
    repeat (150) @(posedge aclk);
    chk({31'h0, loader_active}, 32'h1);
    host_ferr <= 1'b1;
    gpio_in[pin] <= 1'b0;
    for (i = 0; i < 200 && loader_active === 1'b1; i = i + 1) @(posedge aclk);
    if (i == 200) tmo;
    // Verify request is registered one edge after the fresh sample
    @(posedge aclk);
    chk({30'h0, verify_req, 1'(i > 35 && i < 70)}, 32'h3);
    $display("loader done");
    end_of_test;
  end
endmodule // secure_boot_mode_selector_tb
